// *** hw/pdp_pkg.sv ***
/*
 * constants, types and timing tables for the prefix decoder and pipeline timing model.
 * assumes one processor clock and a word-wide prefetch feed.
 */
package pdp_pkg;

    localparam int WORD_W         = 32;
    localparam int NIB_W          = 4;
    localparam int STAGES         = 5;
    localparam int BYTES_PER_WORD = 4;
    localparam int FETCH_DEPTH    = 4;
    localparam int LAT_W          = 10;
    localparam int STALL_W        = 12;

    localparam logic [3:0] FN_JUMP      = 4'h0;
    localparam logic [3:0] FN_LOCAL_PTR = 4'h1;
    localparam logic [3:0] FN_PFIX      = 4'h2;
    localparam logic [3:0] FN_LOAD_NL   = 4'h3;
    localparam logic [3:0] FN_LDC       = 4'h4;
    localparam logic [3:0] FN_NL_PTR    = 4'h5;
    localparam logic [3:0] FN_NFIX      = 4'h6;
    localparam logic [3:0] FN_LDL       = 4'h7;
    localparam logic [3:0] FN_CALL      = 4'h9;
    localparam logic [3:0] FN_COND      = 4'ha;
    localparam logic [3:0] FN_STL       = 4'hd;
    localparam logic [3:0] FN_STNL      = 4'he;
    localparam logic [3:0] FN_OPR       = 4'hf;

    localparam logic [2:0] STG_LOCAL = 3'h0;
    localparam logic [2:0] STG_ADDR  = 3'h1;
    localparam logic [2:0] STG_READ  = 3'h2;
    localparam logic [2:0] STG_ALU   = 3'h3;
    localparam logic [2:0] STG_STORE = 3'h4;
    localparam logic [2:0] STG_NONE  = 3'h7;

    localparam logic [STALL_W-1:0] PEN_JUMP       = 12'h002;
    localparam logic [STALL_W-1:0] PEN_COND_TAKEN = 12'h004;
    localparam logic [STALL_W-1:0] PEN_LOOP_BACK  = 12'h002;
    localparam logic [STALL_W-1:0] PEN_LOOP_EXIT  = 12'h005;
    localparam logic [STALL_W-1:0] PEN_CALL       = 12'h003;
    localparam logic [STALL_W-1:0] PEN_SUB_EXIT   = 12'h002;
    localparam logic [STALL_W-1:0] PEN_LS_ADDR    = 12'h002;
    localparam logic [STALL_W-1:0] LS_GAP_RELIEF  = 12'h001;
    localparam logic [1:0]         LS_LATE_AGE    = 2'h2;
    localparam logic [LAT_W-1:0]   DENORM_CYCLES  = 10'h002;

    typedef enum logic [1:0] {PDP_OPR_ALU, PDP_OPR_ADDR, PDP_OPR_LOAD, PDP_OPR_PUSH} pdp_opr_kind_t;
    typedef enum logic [1:0] {PDP_JMP_NONE, PDP_JMP_LOOP_BACK, PDP_JMP_LOOP_EXIT, PDP_JMP_SUB_EXIT} pdp_opr_jump_t;
    typedef enum logic [4:0] {
        PDP_ALU_ONE, PDP_ALU_UNCHECKED_PRODUCT, PDP_ALU_CHECKED_TIMES, PDP_ALU_CHECKED_QUOTIENT,
        PDP_ALU_INTEGER_MODULUS, PDP_ALU_LONG_TIMES, PDP_ALU_LONG_QUOTIENT, PDP_ALU_LONG_SHIFT_RIGHT,
        PDP_ALU_LONG_SHIFT_LEFT, PDP_ALU_BYTE_CHECKSUM_STEP, PDP_ALU_WORD_CHECKSUM_STEP, PDP_ALU_FLOAT_SUM,
        PDP_ALU_FLOAT_DIFFERENCE, PDP_ALU_FLOAT_TIMES, PDP_ALU_FLOAT_QUOTIENT, PDP_ALU_FLOAT_ROOT,
        PDP_ALU_FLOAT_REMAINDER, PDP_ALU_FLOAT_RANGE_REDUCE
    } pdp_alu_class_t;

    // {least, most} cycles; dbl selects double precision
    function automatic logic [2*LAT_W-1:0] pdp_latency(input pdp_alu_class_t cls, input logic dbl);
        unique case (cls)
            PDP_ALU_UNCHECKED_PRODUCT, PDP_ALU_CHECKED_TIMES: pdp_latency = {10'd2, 10'd5};
            PDP_ALU_CHECKED_QUOTIENT:   pdp_latency = {10'd5, 10'd12};
            PDP_ALU_INTEGER_MODULUS:    pdp_latency = {10'd6, 10'd13};
            PDP_ALU_LONG_TIMES:         pdp_latency = {10'd3, 10'd6};
            PDP_ALU_LONG_QUOTIENT:      pdp_latency = {10'd15, 10'd15};
            PDP_ALU_LONG_SHIFT_RIGHT, PDP_ALU_LONG_SHIFT_LEFT: pdp_latency = {10'd2, 10'd2};
            PDP_ALU_BYTE_CHECKSUM_STEP: pdp_latency = {10'd4, 10'd4};
            PDP_ALU_WORD_CHECKSUM_STEP: pdp_latency = {10'd16, 10'd16};
            PDP_ALU_FLOAT_SUM, PDP_ALU_FLOAT_DIFFERENCE: pdp_latency = {10'd2, 10'd2};
            PDP_ALU_FLOAT_TIMES:        pdp_latency = dbl ? {10'd3, 10'd3} : {10'd2, 10'd2};
            PDP_ALU_FLOAT_QUOTIENT, PDP_ALU_FLOAT_ROOT: pdp_latency = dbl ? {10'd15, 10'd15} : {10'd8, 10'd8};
            PDP_ALU_FLOAT_REMAINDER:    pdp_latency = dbl ? {10'd5, 10'd529} : {10'd5, 10'd74};
            PDP_ALU_FLOAT_RANGE_REDUCE: pdp_latency = dbl ? {10'd5, 10'd17} : {10'd5, 10'd10};
            default:                    pdp_latency = {10'd1, 10'd1};
        endcase
    endfunction

endpackage

// *** hw/pdp_decoder.sv ***
/*
 * byte-instruction decoder with operand prefixing, prefetch word buffer and
 * a cycle-level timing model of the five-stage grouped pipeline.
 * assumes fetch words and group attribute inputs are synchronous to clock;
 * attributes describe the group shown on group_* in the same cycle.
 */
`timescale 1ns/1ps

// Summary of operation
// [RULE1] byte splits into function and data nibbles
// [RULE2] 2 positive prefix, 6 negative, F operate
// [RULE3] data nibble enters operand low bits
// [RULE4] non-prefix instructions clear operand register after
// [RULE5] positive prefix inserts nibble, shifts left four
// [RULE6] negative prefix inserts, complements, then shifts
// [RULE7] chains reach full width; one prefix spans -256..255
// [RULE8] operate uses operand as stack operation code
// [RULE9] five stages: local, address, read, alu, store
// [RULE10] prefixes merge with their instruction into groups
// [RULE11] unstalled groups complete one per cycle
// [RULE12] alu and fpu default to one cycle
// [RULE13] integer long-operation latencies from table
// [RULE14] floating latencies per precision from table
// [RULE15] denormal adds two cycles, except remainder result
// [RULE16] stack conflict stalls produce minus consume stage
// [RULE17] per-instruction produce and consume stages
// [RULE18] load after pending store waits at use
// [RULE19] stage three use free, stage one two
// [RULE20] load one cycle later: penalty one less
// [RULE21] jump refill penalties per jump kind
// [RULE22] cache miss adds memory-dependent refill cycles
// [RULE23] word fetch delivers four bytes to buffer
// [RULE24] jump discards prefetch buffer and refetches
// [RULE25] operand register 32 bits, overflow discarded
module pdp_decoder #(
    parameter int DEPTH = pdp_pkg::FETCH_DEPTH
) (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       reset_n,
    // prefetch fill
    input  wire logic                       fetch_valid,
    input  wire logic [31:0]                fetch_word,
    output logic                            fetch_ready,
    output logic                            fetch_redirect,
    // group issue
    output logic                            group_valid,
    output logic [3:0]                      group_func,
    output logic [31:0]                     group_operand,
    // group attributes, sampled while group_valid
    input  wire pdp_pkg::pdp_opr_kind_t     opr_kind,
    input  wire pdp_pkg::pdp_opr_jump_t     opr_jump,
    input  wire pdp_pkg::pdp_alu_class_t    alu_class,
    input  wire logic                       alu_double,
    input  wire logic [9:0]                 alu_data_cycles,
    input  wire logic [1:0]                 denorm_operands,
    input  wire logic                       denorm_result,
    input  wire logic                       cond_taken,
    input  wire logic                       load_hits_store,
    input  wire logic [7:0]                 miss_cycles,
    // status
    output logic [4:0]                      stage_busy,
    output logic                            decode_stall
);

    localparam int AW = $clog2(DEPTH);

    logic [31:0]                mem [DEPTH];
    logic [AW-1:0]              wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [AW:0]                count_q, count_d;
    logic [1:0]                 byte_sel_q, byte_sel_d;
    logic [31:0]                oreg_q, oreg_d;
    logic                       grp_v_q, grp_v_d;
    logic [3:0]                 grp_f_q, grp_f_d;
    logic [31:0]                grp_op_q, grp_op_d;
    logic [pdp_pkg::STALL_W-1:0] stall_q, stall_d;
    logic [2:0]                 prev_prod_q, prev_prod_d;
    logic [1:0]                 store_age_q, store_age_d;
    logic [4:0]                 stage_q, stage_d;
    logic                       redir_q, redir_d;

    logic [7:0]                 cur_byte;
    logic [3:0]                 cur_func, cur_data;
    logic [31:0]                operand_now;
    logic                       is_prefix, dec_go, push, pop, jump_now;
    logic [2:0]                 cons_stg, prod_stg;
    logic [pdp_pkg::STALL_W-1:0] stack_pen, ls_pen, alu_pen, jump_pen;

    // consumed stage of a group
    function automatic logic [2:0] cons_stage(input logic [3:0] f, input pdp_pkg::pdp_opr_kind_t k);
        unique case (f)
            pdp_pkg::FN_LOAD_NL, pdp_pkg::FN_NL_PTR: cons_stage = pdp_pkg::STG_ADDR;
            pdp_pkg::FN_COND, pdp_pkg::FN_STL, pdp_pkg::FN_STNL: cons_stage = pdp_pkg::STG_STORE;
            pdp_pkg::FN_OPR: cons_stage = (k == pdp_pkg::PDP_OPR_ALU) ? pdp_pkg::STG_ALU :
                                          (k == pdp_pkg::PDP_OPR_PUSH) ? pdp_pkg::STG_NONE : pdp_pkg::STG_ADDR;
            default: cons_stage = pdp_pkg::STG_NONE;
        endcase
    endfunction

    // produced stage of a group
    function automatic logic [2:0] prod_stage(input logic [3:0] f, input pdp_pkg::pdp_opr_kind_t k);
        unique case (f)
            pdp_pkg::FN_LDC, pdp_pkg::FN_LDL, pdp_pkg::FN_LOCAL_PTR: prod_stage = pdp_pkg::STG_LOCAL;
            pdp_pkg::FN_NL_PTR: prod_stage = pdp_pkg::STG_ADDR;
            pdp_pkg::FN_LOAD_NL: prod_stage = pdp_pkg::STG_READ;
            pdp_pkg::FN_OPR: unique case (k)
                pdp_pkg::PDP_OPR_ALU:  prod_stage = pdp_pkg::STG_ALU;
                pdp_pkg::PDP_OPR_ADDR: prod_stage = pdp_pkg::STG_ADDR;
                pdp_pkg::PDP_OPR_LOAD: prod_stage = pdp_pkg::STG_READ;
                pdp_pkg::PDP_OPR_PUSH: prod_stage = pdp_pkg::STG_LOCAL;
            endcase
            default: prod_stage = pdp_pkg::STG_NONE;
        endcase
    endfunction

    // alu latency with data dependent clamp and denormal overhead
    function automatic logic [pdp_pkg::STALL_W-1:0] alu_extra(input pdp_pkg::pdp_alu_class_t c, input logic dbl,
            input logic [9:0] dc, input logic [1:0] dn_op, input logic dn_res);
        logic [2*pdp_pkg::LAT_W-1:0] mm;
        logic [9:0]                  lat;
        logic [1:0]                  dn_res_cnt;
        mm = pdp_pkg::pdp_latency(c, dbl);
        lat = (dc < mm[19:10]) ? mm[19:10] : (dc > mm[9:0]) ? mm[9:0] : dc;
        dn_res_cnt = {1'b0, dn_res && (c != pdp_pkg::PDP_ALU_FLOAT_REMAINDER)};
        alu_extra = STALL_W_CAST(lat) - 12'h001 + STALL_W_CAST(pdp_pkg::DENORM_CYCLES * 10'(dn_op + dn_res_cnt));
    endfunction

    function automatic logic [pdp_pkg::STALL_W-1:0] STALL_W_CAST(input logic [9:0] v);
        STALL_W_CAST = {2'b00, v};
    endfunction

    // word in, four bytes out, lowest byte first
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_q] <= fetch_word; // [RULE23]
        end
    end

    assign cur_byte    = mem[rd_ptr_q][8*byte_sel_q +: 8];
    assign cur_func    = cur_byte[7:4]; // [RULE1]
    assign cur_data    = cur_byte[3:0];
    assign operand_now = {oreg_q[31:4], cur_data}; // [RULE3]
    assign is_prefix   = (cur_func == pdp_pkg::FN_PFIX) || (cur_func == pdp_pkg::FN_NFIX); // [RULE2]

    // the jump is known only while its group is shown, so decode holds that cycle
    always_comb begin
        jump_now = 1'b0;
        if (grp_v_q) begin
            unique case (grp_f_q)
                pdp_pkg::FN_JUMP, pdp_pkg::FN_CALL: jump_now = 1'b1;
                pdp_pkg::FN_COND: jump_now = cond_taken;
                pdp_pkg::FN_OPR:  jump_now = (opr_jump != pdp_pkg::PDP_JMP_NONE);
                default:          jump_now = 1'b0;
            endcase
        end
    end

    assign fetch_ready = (count_q < (AW+1)'(DEPTH)) && !jump_now;
    assign push        = fetch_valid && fetch_ready;
    assign dec_go      = (count_q != '0) && (stall_q == '0) && !jump_now; // [RULE11]
    assign pop         = dec_go && (byte_sel_q == 2'h3);

    // timing model terms for the group on show
    always_comb begin
        cons_stg = cons_stage(grp_f_q, opr_kind); // [RULE17]
        prod_stg = prod_stage(grp_f_q, opr_kind);
        stack_pen = '0;
        if (prev_prod_q != pdp_pkg::STG_NONE && cons_stg != pdp_pkg::STG_NONE && prev_prod_q > cons_stg) begin
            stack_pen = 12'(prev_prod_q - cons_stg); // [RULE16]
        end
        ls_pen = '0;
        if (load_hits_store && store_age_q != '0 && store_age_q != 2'h3
                && cons_stg == pdp_pkg::STG_ADDR) begin // [RULE18]
            ls_pen = pdp_pkg::PEN_LS_ADDR; // [RULE19]
            if (store_age_q == pdp_pkg::LS_LATE_AGE) begin
                ls_pen = pdp_pkg::PEN_LS_ADDR - pdp_pkg::LS_GAP_RELIEF; // [RULE20]
            end
        end
        alu_pen = '0;
        if (grp_f_q == pdp_pkg::FN_OPR && opr_kind == pdp_pkg::PDP_OPR_ALU) begin // [RULE8]
            // [RULE12] [RULE13] [RULE14] [RULE15]
            alu_pen = alu_extra(alu_class, alu_double, alu_data_cycles, denorm_operands, denorm_result);
        end
        jump_pen = '0;
        unique case (grp_f_q)
            pdp_pkg::FN_JUMP: jump_pen = pdp_pkg::PEN_JUMP; // [RULE21]
            pdp_pkg::FN_CALL: jump_pen = pdp_pkg::PEN_CALL;
            pdp_pkg::FN_COND: jump_pen = cond_taken ? pdp_pkg::PEN_COND_TAKEN : '0;
            pdp_pkg::FN_OPR: unique case (opr_jump)
                pdp_pkg::PDP_JMP_LOOP_BACK: jump_pen = pdp_pkg::PEN_LOOP_BACK;
                pdp_pkg::PDP_JMP_LOOP_EXIT: jump_pen = pdp_pkg::PEN_LOOP_EXIT;
                pdp_pkg::PDP_JMP_SUB_EXIT:  jump_pen = pdp_pkg::PEN_SUB_EXIT;
                pdp_pkg::PDP_JMP_NONE:      jump_pen = '0;
            endcase
            default: jump_pen = '0;
        endcase
        if (jump_now) begin
            jump_pen = jump_pen + {4'h0, miss_cycles}; // [RULE22]
        end
    end

    always_comb begin
        wr_ptr_d    = wr_ptr_q;
        rd_ptr_d    = rd_ptr_q;
        count_d     = count_q;
        byte_sel_d  = byte_sel_q;
        oreg_d      = oreg_q;
        grp_v_d     = 1'b0;
        grp_f_d     = grp_f_q;
        grp_op_d    = grp_op_q;
        stall_d     = (stall_q != '0) ? stall_q - 12'h001 : '0;
        prev_prod_d = prev_prod_q;
        store_age_d = (store_age_q != '0 && store_age_q != 2'h3) ? store_age_q + 2'h1 : store_age_q;
        stage_d     = {stage_q[3:0], grp_v_q && stall_q == '0}; // [RULE9]
        redir_d     = jump_now;
        if (grp_v_q) begin
            stall_d     = stall_d + ((stack_pen > ls_pen) ? stack_pen : ls_pen) + alu_pen + jump_pen;
            prev_prod_d = prod_stg;
            if (grp_f_q == pdp_pkg::FN_STL || grp_f_q == pdp_pkg::FN_STNL) begin
                store_age_d = 2'h1;
            end
        end
        if (dec_go) begin
            byte_sel_d = byte_sel_q + 2'h1;
            unique case (cur_func)
                pdp_pkg::FN_PFIX: oreg_d = {operand_now[27:0], 4'h0}; // [RULE5] [RULE25] [RULE7]
                pdp_pkg::FN_NFIX: oreg_d = {~operand_now[27:0], 4'h0}; // [RULE6]
                default: begin
                    oreg_d   = '0; // [RULE4]
                    grp_v_d  = 1'b1; // [RULE10]
                    grp_f_d  = cur_func;
                    grp_op_d = operand_now;
                end
            endcase
        end
        if (pop) begin
            rd_ptr_d = rd_ptr_q + AW'(1);
        end
        if (push) begin
            wr_ptr_d = wr_ptr_q + AW'(1);
        end
        count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
        if (jump_now) begin
            // bytes buffered behind a jump are dropped, but a word accepted while fetch_redirect is high is kept and decodes
            wr_ptr_d   = '0; // [RULE24]
            rd_ptr_d   = '0;
            count_d    = '0;
            byte_sel_d = '0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q    <= '0;
            rd_ptr_q    <= '0;
            count_q     <= '0;
            byte_sel_q  <= '0;
            oreg_q      <= '0;
            grp_v_q     <= 1'b0;
            grp_f_q     <= '0;
            grp_op_q    <= '0;
            stall_q     <= '0;
            prev_prod_q <= pdp_pkg::STG_NONE;
            store_age_q <= '0;
            stage_q     <= '0;
            redir_q     <= 1'b0;
        end else begin
            wr_ptr_q    <= wr_ptr_d;
            rd_ptr_q    <= rd_ptr_d;
            count_q     <= count_d;
            byte_sel_q  <= byte_sel_d;
            oreg_q      <= oreg_d;
            grp_v_q     <= grp_v_d;
            grp_f_q     <= grp_f_d;
            grp_op_q    <= grp_op_d;
            stall_q     <= stall_d;
            prev_prod_q <= prev_prod_d;
            store_age_q <= store_age_d;
            stage_q     <= stage_d;
            redir_q     <= redir_d;
        end
    end

    assign group_valid    = grp_v_q;
    assign group_func     = grp_f_q;
    assign group_operand  = grp_op_q;
    assign fetch_redirect = redir_q;
    assign stage_busy     = stage_q;
    assign decode_stall   = (stall_q != '0);

    sequence s_pfix_seen;
        dec_go && cur_func == pdp_pkg::FN_PFIX;
    endsequence

    a_pfix_shift: assert property (@(posedge clock) disable iff (!reset_n) // [RULE5]
        s_pfix_seen |=> oreg_q == {$past(oreg_q[27:4]), $past(cur_data), 4'h0}
        ) else $error("positive prefix did not shift operand");
    a_nfix_comp: assert property (@(posedge clock) disable iff (!reset_n) // [RULE6]
        dec_go && cur_func == pdp_pkg::FN_NFIX |=> oreg_q[3:0] == 4'h0 && oreg_q[7:4] == ~$past(cur_data)
        ) else $error("negative prefix did not complement operand");
    a_oreg_clear: assert property (@(posedge clock) disable iff (!reset_n) // [RULE4]
        dec_go && !is_prefix |=> oreg_q == '0
        ) else $error("operand not cleared after instruction");
    a_group_operand: assert property (@(posedge clock) disable iff (!reset_n) // [RULE3]
        dec_go && !is_prefix |=> group_valid && group_operand == $past(operand_now)
        ) else $error("group operand mismatch");
    a_prefix_merge: assert property (@(posedge clock) disable iff (!reset_n) // [RULE10]
        dec_go && is_prefix |=> !group_valid
        ) else $error("prefix issued as own group");
    a_jump_flush: assert property (@(posedge clock) disable iff (!reset_n) // [RULE24]
        jump_now |=> fetch_redirect && count_q == '0
        ) else $error("jump did not discard prefetch buffer");
    a_stall_hold: assert property (@(posedge clock) disable iff (!reset_n) // [RULE16]
        stall_q != '0 |-> !dec_go
        ) else $error("decode ran during stall");
    a_jump_penalty: assert property (@(posedge clock) disable iff (!reset_n) // [RULE21]
        group_valid && group_func == pdp_pkg::FN_JUMP && miss_cycles == 8'h00 && stall_q == '0
        && stack_pen == '0 && ls_pen == '0
        |=> stall_q == pdp_pkg::PEN_JUMP ##1 stall_q == 12'h001 ##1 stall_q == '0
        ) else $error("jump refill penalty wrong");
    a_stage_flow: assert property (@(posedge clock) disable iff (!reset_n) // [RULE9]
        stage_busy[0] |=> stage_busy[1] ##1 stage_busy[2] ##1 stage_busy[3] ##1 stage_busy[4]
        ) else $error("group left pipeline early");

endmodule

// *** verif/pdp_fetch_model.sv ***
/*
 * prefetch feed model: offers queued fetch words, one word per handshake.
 * assumes the bench pushes words into the words queue; slow adds random gaps.
 */
`timescale 1ns/1ps
module pdp_fetch_model (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // fetch handshake
    input  wire logic        fetch_ready,
    input  wire logic        fetch_redirect,
    input  wire logic        slow,
    output logic             fetch_valid,
    output logic [31:0]      fetch_word
);
    logic [31:0] words[$];
    logic [31:0] last_q;

    initial begin
        fetch_valid = 1'b0;
        fetch_word  = 32'h0;
        last_q      = 32'h0;
    end

    // word-wide feed, low byte decoded first
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fetch_valid <= 1'b0;
        end else begin
            if (fetch_valid && fetch_ready) begin
                last_q = fetch_word;
                void'(words.pop_front());
            end
            if (fetch_redirect) begin
                words.delete();
            end
            if (fetch_valid && !fetch_ready) begin
                fetch_valid <= 1'b1;
            end else if (words.size() > 0 && !(slow && $urandom_range(0, 2) == 0)) begin
                fetch_valid <= 1'b1;
                fetch_word  <= words[0];
            end else begin
                fetch_valid <= 1'b0;
                // idle bus never repeats the last word
                fetch_word  <= ~last_q;
            end
        end
    end
endmodule

// *** verif/pdp_decoder_tb.sv ***
/*
 * bench for pdp_decoder: group operands, prefix chains, stall lengths.
 * assumes pdp_fetch_model on the fetch side.
 */
`timescale 1ns/1ps
module pdp_decoder_tb;
    typedef struct {pdp_pkg::pdp_alu_class_t c; logic d; logic [1:0] dn; logic dr; logic [9:0] dc; int st;} pdp_alu_t;
    logic                    clock, reset_n, slow, fetch_valid, fetch_ready, fetch_redirect;
    logic [31:0]             fetch_word, group_operand, acc;
    logic                    group_valid, decode_stall, alu_double, denorm_result, cond_taken, load_hits_store;
    logic [3:0]              group_func;
    logic [4:0]              stage_busy, sh;
    logic [9:0]              alu_data_cycles;
    logic [1:0]              denorm_operands;
    logic [7:0]              miss_cycles, b, bq[$];
    logic [35:0]             exp_q[$], e;
    pdp_pkg::pdp_opr_kind_t  opr_kind;
    pdp_pkg::pdp_opr_jump_t  opr_jump;
    pdp_pkg::pdp_alu_class_t alu_class;
    int                      error_cnt, check_count, n, v, run, last_run, redirs, m;
    logic [3:0]              fn_tab[10] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'hb, 4'hc, 4'hd, 4'he};
    logic [7:0]              jb[6] = '{8'h02, 8'ha0, 8'h90, 8'hf0, 8'hf0, 8'hf0};
    int                      jp[6] = '{2, 4, 3, 2, 5, 2};
    pdp_pkg::pdp_opr_jump_t  jj[6] = '{pdp_pkg::PDP_JMP_NONE, pdp_pkg::PDP_JMP_NONE, pdp_pkg::PDP_JMP_NONE,
        pdp_pkg::PDP_JMP_LOOP_BACK, pdp_pkg::PDP_JMP_LOOP_EXIT, pdp_pkg::PDP_JMP_SUB_EXIT};
    pdp_alu_t                alu_tab[7] = '{'{pdp_pkg::PDP_ALU_LONG_QUOTIENT, 0, 0, 0, 0, 14},
        '{pdp_pkg::PDP_ALU_FLOAT_TIMES, 1, 0, 0, 0, 2}, '{pdp_pkg::PDP_ALU_FLOAT_QUOTIENT, 0, 0, 0, 0, 7},
        '{pdp_pkg::PDP_ALU_FLOAT_REMAINDER, 1, 0, 1, 529, 528}, '{pdp_pkg::PDP_ALU_CHECKED_QUOTIENT, 0, 0, 0, 3, 4},
        '{pdp_pkg::PDP_ALU_FLOAT_SUM, 0, 2, 0, 0, 5}, '{pdp_pkg::PDP_ALU_WORD_CHECKSUM_STEP, 0, 0, 0, 0, 15}};

    pdp_decoder pdp_decoder_i (.clock(clock), .reset_n(reset_n), .fetch_valid(fetch_valid),
        .fetch_word(fetch_word), .fetch_ready(fetch_ready), .fetch_redirect(fetch_redirect),
        .group_valid(group_valid), .group_func(group_func), .group_operand(group_operand),
        .opr_kind(opr_kind), .opr_jump(opr_jump), .alu_class(alu_class), .alu_double(alu_double),
        .alu_data_cycles(alu_data_cycles), .denorm_operands(denorm_operands), .denorm_result(denorm_result),
        .cond_taken(cond_taken), .load_hits_store(load_hits_store), .miss_cycles(miss_cycles),
        .stage_busy(stage_busy), .decode_stall(decode_stall));
    pdp_fetch_model pdp_fetch_model_i (.clock(clock), .reset_n(reset_n), .fetch_ready(fetch_ready),
        .fetch_redirect(fetch_redirect), .slow(slow), .fetch_valid(fetch_valid), .fetch_word(fetch_word));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic check(input string what, input logic [35:0] x, input logic [35:0] y);
        check_count++;
        if (x !== y) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, x, y);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // reference operand accumulation
    task automatic put(input logic [7:0] x);
        bq.push_back(x);
        acc = {acc[31:4], x[3:0]};
        if (x[7:4] == pdp_pkg::FN_PFIX) begin
            acc = acc << 4;
        end else if (x[7:4] == pdp_pkg::FN_NFIX) begin
            acc = ~acc << 4;
        end else begin
            exp_q.push_back({x[7:4], acc});
            acc = 32'h0;
        end
    endtask

    // pads with load-constant bytes, feeds words, waits until all groups seen
    task automatic flush();
        while (bq.size() % 4 != 0) put(8'h40);
        while (bq.size() > 0) begin
            pdp_fetch_model_i.words.push_back({bq[3], bq[2], bq[1], bq[0]});
            repeat (4) void'(bq.pop_front());
        end
        n = 0;
        while (exp_q.size() > 0 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        if (n >= 3000) begin
            check("drain", 36'h0, 36'(exp_q.size()));
            close_out();
        end
    endtask

    // target byte placed last so its stall shows after the queue empties
    task automatic stall_word(input logic [7:0] p, input logic [7:0] x, input int want);
        last_run = 0;
        repeat (2) put(8'h40);
        put(p);
        put(x);
        flush();
        n = 0;
        while (decode_stall !== 1'b0 && n < 1000) begin
            @(negedge clock);
            n++;
        end
        if (n >= 1000) begin
            check("stall end", 36'h0, 36'h1);
            close_out();
        end
        @(negedge clock);
        check("stall cycles", 36'(want), 36'(last_run));
    endtask

    always @(posedge clock) begin
        if (decode_stall === 1'b1) begin
            run++;
        end else begin
            if (run > 0) last_run = run;
            run = 0;
        end
        if (fetch_redirect === 1'b1) redirs++;
        if (reset_n === 1'b1 && group_valid === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 36'hf_ffff_ffff;
            check("group func and operand", e, {group_func, group_operand});
        end
        if (reset_n === 1'b1) check("stage occupancy", 36'(sh), 36'(stage_busy));
        sh = {sh[3:0], group_valid === 1'b1 && decode_stall === 1'b0};
    end

    initial begin
        {reset_n, slow, alu_double, denorm_result, cond_taken, load_hits_store} = 6'h0;
        {alu_data_cycles, denorm_operands, miss_cycles, acc, sh} = '0;
        {error_cnt, check_count, run, last_run, redirs} = '0;
        opr_kind = pdp_pkg::PDP_OPR_PUSH;
        opr_jump = pdp_pkg::PDP_JMP_NONE;
        alu_class = pdp_pkg::PDP_ALU_ONE;
        void'($urandom(32'h4b1d));
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        foreach (jb[i]) put(jb[i] == 8'h02 ? 8'h21 : 8'h61);
        foreach (fn_tab[i]) put({fn_tab[i], 4'(i)});
        put(8'hf5);
        flush();
        slow <= 1'b1;
        repeat (40) begin
            repeat ($urandom_range(0, 9)) put({$urandom_range(0, 1) ? 4'h2 : 4'h6, 4'($urandom)});
            put({fn_tab[$urandom_range(0, 9)], 4'($urandom)});
        end
        flush();
        // one prefix covers the short signed range
        repeat (30) begin
            v = $urandom_range(0, 511) - 256;
            b = v < 0 ? {4'h6, ~v[7:4]} : {4'h2, v[7:4]};
            bq.push_back(b);
            bq.push_back({4'h4, v[3:0]});
            exp_q.push_back({4'h4, v});
        end
        flush();
        opr_kind <= pdp_pkg::PDP_OPR_ALU;
        foreach (alu_tab[i]) begin
            @(posedge clock);
            alu_class <= alu_tab[i].c;
            alu_double <= alu_tab[i].d;
            denorm_operands <= alu_tab[i].dn;
            denorm_result <= alu_tab[i].dr;
            alu_data_cycles <= alu_tab[i].dc;
            stall_word(8'h40, 8'hf0, alu_tab[i].st);
        end
        opr_kind <= pdp_pkg::PDP_OPR_PUSH;
        alu_class <= pdp_pkg::PDP_ALU_ONE;
        cond_taken <= 1'b1;
        foreach (jb[i]) begin
            @(posedge clock);
            m = $urandom_range(0, 7);
            opr_jump <= jj[i];
            miss_cycles <= 8'(m);
            v = redirs;
            stall_word(8'h40, jb[i], jp[i] + m);
            check("redirect pulses", 36'(v + 1), 36'(redirs));
        end
        // back-to-back non-local loads, then a load right behind a store
        @(posedge clock);
        stall_word(8'h30, 8'h30, 1);
        @(posedge clock);
        load_hits_store <= 1'b1;
        stall_word(8'hd0, 8'h30, 2);
        close_out();
    end
endmodule
